// >>> rtl/command_parser.sv
// ascii command line buffer, splitter and number parser with reply framing
`timescale 1ns/10ps
`default_nettype none
module command_parser
  import cmd_parser_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // received characters from the serial or usb front end
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  // parsed commands and parameters
  output var cmd_t o_cmd,
  output logic o_cmd_valid,
  output var param_t o_param,
  output logic o_param_valid,
  output logic o_line_busy,
  // reply characters from the executor
  input wire logic [7:0] i_reply_data,
  input wire logic i_reply_valid,
  input wire logic i_reply_last,
  output logic o_reply_ready,
  // characters toward the host
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  input wire logic i_tx_ready
);
  typedef enum {S_IDLE, S_FETCH, S_CHAR, S_NORM, S_EMIT, S_END, S_WAIT} state_t;
  typedef enum logic [1:0] {SEG_MNEM, SEG_ARGS, SEG_SKIP} seg_t;
  typedef enum logic [1:0] {END_COMMA, END_SEMI, END_TERM} end_t;

  // ==========================================================
  // input ring buffer
  logic [7:0] mem [BUF_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] buf_count;
  logic [PTR_W:0] line_count;
  logic [7:0] rd_char;
  logic wr_en;
  logic fetch;
  logic term_in;
  logic term_used;
  state_t state;

  // only unread characters block writing; read slots are free for reuse
  assign o_rx_ready = buf_count != BUF_FULL;
  assign wr_en = i_rx_valid && o_rx_ready;
  assign fetch = state == S_FETCH;
  assign term_in = wr_en && is_term(i_rx_data);
  assign term_used = (state == S_CHAR) && is_term(rd_char);

  // storage with registered read port
  always_ff @(posedge i_sys_clk) begin
    if (wr_en) begin
      mem[wr_ptr] <= i_rx_data;
    end
    if (fetch) begin
      rd_char <= mem[rd_ptr];
    end
  end

  // pointers advance one slot per character, so order is kept
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      buf_count <= '0;
    end else begin
      wr_ptr <= PTR_W'(wr_ptr + wr_en);
      rd_ptr <= PTR_W'(rd_ptr + fetch);
      if (wr_en && !fetch) begin
        buf_count <= (PTR_W+1)'(buf_count + 1'b1);
      end else if (fetch && !wr_en) begin
        buf_count <= (PTR_W+1)'(buf_count - 1'b1);
      end
    end
  end

  // complete lines waiting in the buffer
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      line_count <= '0;
    end else if (term_in && !term_used) begin
      line_count <= (PTR_W+1)'(line_count + 1'b1);
    end else if (term_used && !term_in) begin
      line_count <= (PTR_W+1)'(line_count - 1'b1);
    end
  end

  // ==========================================================
  // segment parser
  seg_t seg;
  end_t end_kind;
  logic [31:0] mnem;
  logic [2:0] mn_cnt;
  logic query;
  logic [3:0] nparam;
  chan_t chan;
  logic have_num;
  logic neg;
  logic [31:0] mant;
  logic signed [7:0] exp10;
  logic signed [7:0] exp_val;
  logic in_frac;
  logic in_exp;
  logic exp_neg;
  logic as_arg;
  logic delim;
  logic seg_ok;
  logic reply_done;
  logic [7:0] digit;
  end_t next_kind;
  state_t after_seg;

  assign as_arg = (seg == SEG_ARGS) || (seg == SEG_MNEM && mn_cnt == MNEM_LEN && rd_char != ASCII_QMARK);
  assign delim = is_term(rd_char) || rd_char == ASCII_SEMI || rd_char == ASCII_COMMA;
  assign seg_ok = (seg != SEG_SKIP) && (mn_cnt == MNEM_LEN);
  assign digit = 8'(rd_char - ASCII_ZERO);
  assign next_kind = is_term(rd_char) ? END_TERM : (rd_char == ASCII_SEMI) ? END_SEMI : END_COMMA;
  assign after_seg = (end_kind == END_TERM) ? S_IDLE : S_FETCH;

  // one state machine walks each line; it never yields mid-line
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= S_IDLE;
      seg <= SEG_MNEM;
      end_kind <= END_TERM;
      mnem <= '0;
      mn_cnt <= '0;
      query <= 1'b0;
      nparam <= '0;
      chan <= chan_none;
      have_num <= 1'b0;
      neg <= 1'b0;
      mant <= '0;
      exp10 <= '0;
      exp_val <= '0;
      in_frac <= 1'b0;
      in_exp <= 1'b0;
      exp_neg <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (line_count != '0) begin
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          state <= S_CHAR;
        end
        S_CHAR: begin
          state <= S_FETCH;
          if (seg == SEG_SKIP) begin
            // malformed mnemonic: swallow commas and all up to the next semicolon or terminator
            if (is_term(rd_char) || rd_char == ASCII_SEMI) begin
              end_kind <= next_kind;
              state <= S_END;
            end
          end else if (as_arg) begin
            seg <= SEG_ARGS;
            if (delim) begin
              end_kind <= next_kind;
              // fold the written exponent into the fraction shift
              exp10 <= 8'(exp10 + (exp_neg ? -exp_val : exp_val));
              if (have_num) begin
                state <= S_NORM;
              end else if (rd_char != ASCII_COMMA) begin
                state <= S_END;
              end
            end else if (is_digit(rd_char)) begin
              have_num <= 1'b1;
              if (in_exp) begin
                exp_val <= 8'(exp_val * 8'sd10 + $signed(digit));
              end else begin
                mant <= 32'(mant * 32'd10 + {24'h000000, digit});
                if (in_frac) begin
                  exp10 <= 8'(exp10 - 8'sd1);
                end
              end
            end else if (rd_char == ASCII_DOT) begin
              in_frac <= 1'b1;
            end else if (rd_char == ASCII_UPPER_E || rd_char == ASCII_LOWER_E) begin
              in_exp <= 1'b1;
            end else if (rd_char == ASCII_MINUS) begin
              if (in_exp) begin
                exp_neg <= 1'b1;
              end else begin
                neg <= 1'b1;
              end
            end
          end else if (mn_cnt == MNEM_LEN) begin
            query <= 1'b1;
            seg <= SEG_ARGS;
          end else if (is_upper(rd_char)) begin
            mnem <= {mnem[23:0], rd_char};
            mn_cnt <= 3'(mn_cnt + 1'b1);
          end else if (is_term(rd_char) || rd_char == ASCII_SEMI) begin
            end_kind <= next_kind;
            state <= S_END;
          end else begin
            seg <= SEG_SKIP;
          end
        end
        S_NORM: begin
          // strip trailing zeros so 5, 5.0 and .5E1 leave the same pair
          if (mant != '0 && (mant % 32'd10) == '0) begin
            mant <= mant / 32'd10;
            exp10 <= 8'(exp10 + 8'sd1);
          end else begin
            state <= S_EMIT;
          end
        end
        S_EMIT: begin
          if (nparam == '0) begin
            if (!neg && exp10 == '0 && mant == 32'd1) begin
              chan <= first_measurement_channel;
            end else if (!neg && exp10 == '0 && mant == 32'd2) begin
              chan <= second_measurement_channel;
            end
          end
          nparam <= 4'(nparam + 1'b1);
          have_num <= 1'b0;
          neg <= 1'b0;
          mant <= '0;
          exp10 <= '0;
          exp_val <= '0;
          in_frac <= 1'b0;
          in_exp <= 1'b0;
          exp_neg <= 1'b0;
          state <= (end_kind == END_COMMA) ? S_FETCH : S_END;
        end
        S_END: begin
          seg <= SEG_MNEM;
          mn_cnt <= '0;
          query <= 1'b0;
          nparam <= '0;
          chan <= chan_none;
          state <= (seg_ok && query) ? S_WAIT : after_seg;
          exp10 <= '0;
          exp_val <= '0;
          exp_neg <= 1'b0;
        end
        S_WAIT: begin
          if (reply_done) begin
            state <= after_seg;
          end
        end
      endcase
    end
  end

  // outputs toward the executor, registered
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_cmd_valid <= 1'b0;
      o_param_valid <= 1'b0;
      o_cmd <= '0;
      o_param <= '0;
    end else begin
      o_cmd_valid <= (state == S_END) && seg_ok;
      o_param_valid <= state == S_EMIT;
      if (state == S_END) begin
        o_cmd <= '{mnem: mnem, query: query, nparam: nparam, chan: chan};
      end
      if (state == S_EMIT) begin
        o_param <= '{index: nparam, neg: neg, mant: mant, exp10: exp10};
      end
    end
  end

  // busy spans the whole line so other actions wait for it
  assign o_line_busy = state != S_IDLE;

  // ==========================================================
  // reply framing and output queue
  logic term_pend;
  logic push_valid;
  logic push_ready;
  logic [7:0] push_data;

  // replies are taken only while a query waits, so order follows the queries
  assign o_reply_ready = push_ready && !term_pend && state == S_WAIT;
  assign reply_done = i_reply_valid && o_reply_ready && i_reply_last;
  assign push_valid = term_pend || (i_reply_valid && state == S_WAIT);
  assign push_data = term_pend ? REPLY_TERM : i_reply_data;

  // terminator queued right after each reply's last character
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      term_pend <= 1'b0;
    end else if (reply_done) begin
      term_pend <= 1'b1;
    end else if (term_pend && push_ready) begin
      term_pend <= 1'b0;
    end
  end

  reply_fifo #(
    .WIDTH(CHAR_W),
    .DEPTH(REPLY_DEPTH)
  ) u_reply_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_data(push_data),
    .i_in_valid(push_valid),
    .o_in_ready(push_ready),
    .o_out_data(o_tx_data),
    .o_out_valid(o_tx_valid),
    .i_out_ready(i_tx_ready)
  );

  // ==========================================================
  // assertions
  a_no_early_parse: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state == S_IDLE && line_count == '0) |=> state == S_IDLE)
    else $error("parser left idle without a complete line");
  a_term_counted: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (term_in && !term_used) |=> line_count == (PTR_W+1)'($past(line_count) + 1'b1))
    else $error("terminator did not add a line");
  a_read_in_order: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    fetch |=> rd_ptr == PTR_W'($past(rd_ptr) + 1'b1) ##0 state == S_CHAR)
    else $error("read pointer skipped");
  a_full_stalls: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (buf_count == BUF_FULL && !fetch) |=> buf_count == BUF_FULL && !o_rx_ready)
    else $error("unread characters overwritten");
  a_comma_split: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state == S_CHAR && seg == SEG_ARGS && rd_char == ASCII_COMMA && have_num) |=> state == S_NORM)
    else $error("comma did not close a field");
  a_query_waits: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state == S_END && seg_ok && query) |=> state == S_WAIT ##1 o_cmd.query)
    else $error("query did not wait for its reply");
  a_reply_term: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    reply_done |=> push_valid && push_data == REPLY_TERM && !o_reply_ready)
    else $error("reply not closed by terminator");
  a_line_atomic: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state == S_WAIT && !reply_done) |=> state == S_WAIT && o_line_busy)
    else $error("line released before reply");
  a_value_normal: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_param_valid |-> (o_param.mant == '0 || (o_param.mant % 32'd10) != '0))
    else $error("parameter value not normalised");
  a_chan_map: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_cmd_valid && o_cmd.nparam != '0 && o_cmd.chan == first_measurement_channel)
      |-> $past(o_param.mant, 1) != 32'd2 || $past(o_param.index, 1) != '0)
    else $error("channel two mapped to channel one");
  a_mnem_upper: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_cmd_valid |-> is_upper(o_cmd.mnem[7:0]) && is_upper(o_cmd.mnem[31:24]))
    else $error("malformed mnemonic issued");
endmodule
`default_nettype wire

// >>> rtl/cmd_parser_pkg.sv
// shared constants, types and helpers for the ascii command parser
`default_nettype none
package cmd_parser_pkg;
  // ==========================================================
  // buffer geometry
  localparam int BUF_DEPTH = 256;
  localparam int PTR_W = 8;
  localparam logic [8:0] BUF_FULL = 9'h100;
  localparam logic [2:0] MNEM_LEN = 3'h4;
  localparam int REPLY_DEPTH = 4;
  localparam int CHAR_W = 8;
  // ==========================================================
  // character codes
  localparam logic [7:0] ASCII_LF = 8'h0A;
  localparam logic [7:0] ASCII_CR = 8'h0D;
  localparam logic [7:0] ASCII_SEMI = 8'h3B;
  localparam logic [7:0] ASCII_COMMA = 8'h2C;
  localparam logic [7:0] ASCII_QMARK = 8'h3F;
  localparam logic [7:0] ASCII_DOT = 8'h2E;
  localparam logic [7:0] ASCII_MINUS = 8'h2D;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_NINE = 8'h39;
  localparam logic [7:0] ASCII_UPPER_A = 8'h41;
  localparam logic [7:0] ASCII_UPPER_Z = 8'h5A;
  localparam logic [7:0] ASCII_UPPER_E = 8'h45;
  localparam logic [7:0] ASCII_LOWER_E = 8'h65;
  localparam logic [7:0] REPLY_TERM = ASCII_LF;
  // ==========================================================
  // types
  typedef enum logic [1:0] {chan_none, first_measurement_channel, second_measurement_channel} chan_t;
  typedef struct packed {
    logic [31:0] mnem;
    logic query;
    logic [3:0] nparam;
    chan_t chan;
  } cmd_t;
  typedef struct packed {
    logic [3:0] index;
    logic neg;
    logic [31:0] mant;
    logic signed [7:0] exp10;
  } param_t;
  // ==========================================================
  // character classes
  function automatic logic is_term(input logic [7:0] c);
    return (c == ASCII_LF) || (c == ASCII_CR);
  endfunction
  function automatic logic is_digit(input logic [7:0] c);
    return (c >= ASCII_ZERO) && (c <= ASCII_NINE);
  endfunction
  function automatic logic is_upper(input logic [7:0] c);
    return (c >= ASCII_UPPER_A) && (c <= ASCII_UPPER_Z);
  endfunction
endpackage
`default_nettype wire

// >>> rtl/reply_fifo.sv
// small valid/ready fifo for outgoing reply characters
`timescale 1ns/10ps
`default_nettype none
module reply_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // fill side
  input wire logic [WIDTH-1:0] i_in_data,
  input wire logic i_in_valid,
  output logic o_in_ready,
  // drain side
  output logic [WIDTH-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] count;
  logic push;
  logic pop;

  // handshakes; full and empty come straight from the occupancy count
  assign o_in_ready = count != FULL_CNT;
  assign o_out_valid = count != '0;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_idx];

  // storage
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_idx] <= i_in_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == LAST_IDX) ? '0 : AW'(wr_idx + 1'b1);
      end
      if (pop) begin
        rd_idx <= (rd_idx == LAST_IDX) ? '0 : AW'(rd_idx + 1'b1);
      end
      if (push && !pop) begin
        count <= (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
        count <= (AW+1)'(count - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/host_model.sv
// host-side model: sends ascii command lines and drains reply characters
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input wire logic i_sys_clk,
  // toward the parser
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  // from the parser
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready
);
  logic [7:0] got[$];
  logic stall = 1'b0;
  logic slow = 1'b0;
  int timeouts = 0;
  initial begin
    o_rx_data = 8'h00;
    o_rx_valid = 1'b0;
  end
  // ==========================================================
  // sending side
  // one character, held until the edge that finds ready high
  task automatic put(input logic [7:0] c);
    int n;
    n = 0;
    o_rx_data <= c;
    o_rx_valid <= 1'b1;
    @(negedge i_sys_clk);
    while (!i_rx_ready && n < 4000) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n >= 4000) timeouts++;
    @(posedge i_sys_clk);
  endtask
  // caller supplies mnemonic, arguments and terminator; baud rate and parity
  // live outside this block, so the byte stream is the same on either transport
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++) put(s[i]);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~o_rx_data; // released line does not keep the last char
    @(posedge i_sys_clk); // an edge passes so the next line never re-raises valid in the same step
  endtask
  // ==========================================================
  // receiving side
  // slow mode takes every other cycle; stall blocks the output fifo
  always @(posedge i_sys_clk) begin
    if (i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
    o_tx_ready <= !stall && (!slow || !o_tx_ready);
  end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the ascii command parser
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cmd_parser_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_rx_data;
  logic i_rx_valid;
  logic o_rx_ready;
  cmd_t o_cmd;
  logic o_cmd_valid;
  param_t o_param;
  logic o_param_valid;
  logic o_line_busy;
  logic [7:0] i_reply_data = 8'h00;
  logic i_reply_valid = 1'b0;
  logic i_reply_last = 1'b0;
  logic o_reply_ready;
  logic [7:0] o_tx_data;
  logic o_tx_valid;
  logic i_tx_ready;
  cmd_t cmds[$];
  param_t prms[$];
  logic [8:0] rq[$];
  logic saw_full = 1'b0;
  logic watch = 1'b0;
  logic gap = 1'b0;
  int mismatches = 0;
  int total_checks = 0;

  command_parser dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_rx_data(i_rx_data), .i_rx_valid(i_rx_valid),
    .o_rx_ready(o_rx_ready), .o_cmd(o_cmd), .o_cmd_valid(o_cmd_valid), .o_param(o_param),
    .o_param_valid(o_param_valid), .o_line_busy(o_line_busy), .i_reply_data(i_reply_data),
    .i_reply_valid(i_reply_valid), .i_reply_last(i_reply_last), .o_reply_ready(o_reply_ready),
    .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready));
  host_model host (.i_sys_clk(i_sys_clk), .o_rx_data(i_rx_data), .o_rx_valid(i_rx_valid),
    .i_rx_ready(o_rx_ready), .i_tx_data(o_tx_data), .i_tx_valid(o_tx_valid), .o_tx_ready(i_tx_ready));

  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  // ==========================================================
  // executor stand-in
  // logs parser output; each query is answered by first and last mnemonic letters
  always @(posedge i_sys_clk) begin
    if (o_cmd_valid) cmds.push_back(o_cmd);
    if (o_param_valid) prms.push_back(o_param);
    if (watch && !o_line_busy) gap <= 1'b1;
    if (i_reply_valid && !o_reply_ready && host.stall) saw_full <= 1'b1;
    if (i_reply_valid && o_reply_ready) rq.delete(0);
    if (o_cmd_valid && o_cmd.query) begin
      rq.push_back({1'b0, o_cmd.mnem[31:24]});
      rq.push_back({1'b1, o_cmd.mnem[7:0]});
    end
    i_reply_valid <= rq.size() != 0;
    {i_reply_last, i_reply_data} <= (rq.size() != 0) ? rq[0] : {1'b0, ~i_reply_data};
  end
  // ==========================================================
  // helpers
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (!ok) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // a bounded wait that ran out ends the run as a failure
  task automatic ran_out(input logic hit, input string m);
    if (hit) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
      test_done();
    end
  endtask
  // bounded wait for n commands and an idle parser
  task automatic wait_cmds(input int n);
    int k;
    k = 0;
    while ((cmds.size() < n || o_line_busy !== 1'b0) && k < 5000) begin
      @(posedge i_sys_clk);
      k++;
    end
    ran_out(k >= 5000 || host.timeouts != 0, "parser hung or host starved");
  endtask
  function automatic cmd_t mk(input string m, input logic q, input logic [3:0] np, input chan_t ch);
    cmd_t c;
    c.mnem = {m[0], m[1], m[2], m[3]};
    c.query = q;
    c.nparam = np;
    c.chan = ch;
    return c;
  endfunction
  function automatic param_t mkp(input logic [3:0] ix, input logic ng, input logic [31:0] m);
    param_t p;
    p.index = ix;
    p.neg = ng;
    p.mant = m;
    p.exp10 = 8'sh00;
    return p;
  endfunction
  task automatic clear();
    cmds.delete();
    prms.delete();
    host.got.delete();
  endtask
  // ==========================================================
  // scenarios
  // nothing decoded before the terminator; both terminators end a line
  task automatic t_single();
    clear();
    host.send_line("FREQ2");
    repeat (20) @(posedge i_sys_clk);
    chk(o_line_busy === 1'b0 && cmds.size() == 0, "line started before terminator");
    host.send_line("\r");
    host.send_line("FMOD1\n");
    wait_cmds(2);
    chk(cmds.size() == 2 && cmds[0] === mk("FREQ", 0, 1, second_measurement_channel), "cr line");
    chk(cmds[1] === mk("FMOD", 0, 1, first_measurement_channel), "lf line");
    chk(prms.size() == 2 && prms[0] === mkp(0, 0, 2) && prms[1] === mkp(0, 0, 1), "single params");
  endtask
  // mixed line with a bad segment and two queries while the host stalls
  task automatic t_multi();
    string e;
    int k;
    e = "OP\nFD\n";
    clear();
    host.stall = 1'b1;
    host.send_line("PHAS1,-1.5E1;AB1C,9;OUTP?;FMOD?2\n");
    k = 0;
    while (cmds.size() == 0 && k < 2000) begin
      @(posedge i_sys_clk);
      k++;
    end
    ran_out(k >= 2000, "mixed line gave no command");
    watch = 1'b1;
    k = 0;
    while (!saw_full && k < 2000) begin
      @(posedge i_sys_clk);
      k++;
    end
    chk(saw_full === 1'b1 && o_tx_valid === 1'b1, "reply fifo never refused");
    ran_out(k >= 2000, "reply fifo never filled");
    host.stall = 1'b0;
    host.slow = 1'b1;
    k = 0;
    while (cmds.size() < 3 && k < 2000) begin
      @(posedge i_sys_clk);
      k++;
    end
    ran_out(k >= 2000, "mixed line stalled");
    watch = 1'b0;
    wait_cmds(3);
    repeat (30) @(posedge i_sys_clk);
    chk(gap === 1'b0, "line not atomic");
    chk(cmds.size() == 3 && cmds[0] === mk("PHAS", 0, 2, first_measurement_channel), "set cmd");
    chk(cmds[1] === mk("OUTP", 1, 0, chan_none) && cmds[2] === mk("FMOD", 1, 1, second_measurement_channel),
      "query cmds");
    chk(prms.size() == 3 && prms[1] === mkp(1, 1, 15) && prms[2] === mkp(0, 0, 2), "fields");
    chk(host.got.size() == e.len(), "reply count");
    for (int i = 0; i < e.len() && i < host.got.size(); i++) chk(host.got[i] === e[i], "reply char");
    host.slow = 1'b0;
  endtask
  // integer, decimal and exponent forms of five
  task automatic t_nums();
    clear();
    host.send_line("FREQ5;FREQ5.0;FREQ.5E1\n");
    wait_cmds(3);
    chk(prms.size() == 3, "number count");
    foreach (prms[i]) chk(prms[i] === mkp(0, 0, 5), "number form");
  endtask
  // a 256 character line fills the buffer; the next line reuses freed slots
  task automatic t_fill();
    string s;
    s = "SEGS";
    repeat (250) s = {s, " "};
    s = {s, "3\n"};
    clear();
    host.send_line(s);
    @(negedge i_sys_clk);
    chk(o_rx_ready === 1'b0, "buffer not full at 256");
    @(posedge i_sys_clk);
    host.send_line("NEXT7\n");
    wait_cmds(2);
    chk(cmds.size() == 2 && cmds[0] === mk("SEGS", 0, 1, chan_none), "first line");
    chk(cmds[1] === mk("NEXT", 0, 1, chan_none) && prms[1] === mkp(0, 0, 7), "wrapped line");
    chk(host.timeouts == 0, "host starved");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    t_single();
    t_multi();
    t_nums();
    t_fill();
    test_done();
  end
endmodule
`default_nettype wire
